// file: rtl/clock_control_pkg.sv
// Constants, field layout and state encodings for the oscillator clock control
package clock_control_pkg;
  localparam logic [23:0] TIMER_CTRL_ADDR = 24'h00ff40;
  localparam logic [23:0] OSC_CTRL_ADDR = 24'h00ff02;
  localparam logic [23:0] STATUS_ADDR = 24'h00ff03;
  localparam int DIV_SEL_MSB = 6;
  localparam int DIV_SEL_LSB = 4;
  localparam int DIV_EN_BIT = 3;
  localparam int WD_RESTART_BIT = 2;
  localparam int TIMER_RESTART_BIT = 1;
  localparam int TIMER_RUN_BIT = 0;
  localparam int CPU_SEL_BIT = 3;
  localparam int HIGH_EN_BIT = 2;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_LOW_POWER = 2'h1;
  localparam logic [1:0] MODE_HIGH_SPEED = 2'h2;
  localparam logic [2:0] DIV_HIGH_BIT = 3'h4;
  // High oscillator edges seen before it counts as running
  localparam int STABLE_TICKS = 4;
  // Low oscillator nominal rate, in Hz
  localparam int LOW_OSC_HZ = 32768;
  // Highest high oscillator rate per mode, in kHz
  localparam int NORMAL_MAX_KHZ = 4200;
  localparam int HIGH_SPEED_MAX_KHZ = 8200;
  typedef enum logic [3:0] {
    ON_LOW = 4'h1,
    TO_HIGH = 4'h2,
    ON_HIGH = 4'h4,
    TO_LOW = 4'h8
  } mux_state_e;
endpackage : clock_control_pkg

// file: rtl/divided_clock_if.sv
// Signals between the clock control core and the divided clock output generator
`timescale 1ns/1ps
interface divided_clock_if;
  logic low_level;
  logic high_level;
  logic low_edge;
  logic high_edge;
  logic [2:0] div_sel;
  logic div_en;
  logic div_out;
  modport ctl (output low_level, high_level, low_edge, high_edge, div_sel, div_en, input div_out);
  modport gen (input low_level, high_level, low_edge, high_edge, div_sel, div_en, output div_out);
endinterface : divided_clock_if

// file: rtl/divided_clock_output.sv
// Divided clock output: one of two oscillators divided by 1, 2, 4 or 8
`timescale 1ns/1ps
module divided_clock_output (
  input wire logic clock_in,
  input wire logic resetn_in,
  divided_clock_if.gen dc
);
  logic [2:0] count_ff;
  logic [2:0] nxt_count;
  logic out_ff;
  logic nxt_out;
  logic src_edge;
  logic src_level;

  always_comb begin
    src_edge = dc.div_sel[2] ? dc.high_edge : dc.low_edge;
    src_level = dc.div_sel[2] ? dc.high_level : dc.low_level;
    nxt_count = count_ff;
    nxt_out = 1'b0;
    if (!dc.div_en) begin
      nxt_count = 3'h0;
    end else begin
      if (src_edge) begin
        nxt_count = count_ff + 3'h1;
      end
      case (dc.div_sel[1:0])
        2'h0: nxt_out = src_level;
        2'h1: nxt_out = nxt_count[0];
        2'h2: nxt_out = nxt_count[1];
        default: nxt_out = nxt_count[2];
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      count_ff <= 3'h0;
      out_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      out_ff <= nxt_out;
    end
  end

  assign dc.div_out = out_ff;

  chk_div_off_low: assert property (@(posedge clock_in) disable iff (!resetn_in)
    !dc.div_en |=> !dc.div_out) else $error("divided output active while disabled");
endmodule : divided_clock_output

// file: rtl/clock_control.sv
// Oscillator enables, operating mode, glitch-free CPU clock choice and timer strobes
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1 - A 32.768 kHz low oscillator is the base clock for slow operation.
// RULE2 - After reset the CPU runs from the low oscillator; high oscillator stopped.
// RULE3 - Low oscillator keeps feeding the timers while the CPU uses the high one.
// RULE4 - Sleep stops the low oscillator, delayed until supply detector sampling ends.
// RULE5 - High oscillator stops on sleep or when its enable bit is zero.
// RULE6 - Normal mode after reset; high oscillator allowed up to 4.2 MHz.
// RULE7 - High speed mode allows up to 8.2 MHz; software picks it above 4.2 MHz.
// RULE8 - Software never enables the high oscillator in low power mode.
// RULE9 - Software never swaps normal and high speed modes with the high oscillator on.
// RULE10 - An RC low oscillator forces normal mode, ignoring the mode bits.
// RULE11 - Software picks low or high oscillator as CPU clock at run time.
// RULE12 - Software waits for the high oscillator to settle before selecting it.
// RULE13 - Software turns the high oscillator off right after moving back to low.
// RULE14 - Software waits 5 ms after a mode change before enabling the high oscillator.
// RULE15 - Leaving standby resumes the clock and mode state held before it.
// RULE16 - Software restarts the watchdog at intervals below 3 seconds.
// RULE17 - Mode field: 00 normal, 01 low power, 1x high speed; resets to normal.
// RULE18 - CPU clock select: 1 high, 0 low; resets to zero.
// RULE19 - High oscillator enable: 1 on, 0 off; reads back; resets to zero.
// RULE20 - CPU clock changes source glitch-free, only once the new source runs.
// RULE21 - Selecting the high clock while its oscillator is off is ignored.
////////////////////////////////////////////////////////////////////////////////
module clock_control #(
  parameter int STABLE_TICKS = clock_control_pkg::STABLE_TICKS
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [23:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic low_osc_pin_in,
  input wire logic high_osc_pin_in,
  input wire logic rc_low_osc_in,
  input wire logic sleep_instruction_in,
  input wire logic supply_voltage_detector_sampling_in,
  input wire logic wake_in,
  output logic low_speed_oscillator_enable_out,
  output logic high_speed_oscillator_enable_out,
  output logic cpu_tick_out,
  output logic cpu_on_high_out,
  output logic [1:0] op_mode_out,
  output logic high_speed_mode_out,
  output logic clock_timer_tick_out,
  output logic divided_clock_output_out,
  output logic watchdog_restart_strobe_out,
  output logic clock_timer_restart_strobe_out,
  output logic clock_timer_run_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one is read only by stage two
  logic [2:0] low_sync_ff;
  logic [2:0] high_sync_ff;
  logic [1:0] rc_sync_ff;
  logic low_edge;
  logic high_edge;

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      low_sync_ff <= 3'h0;
      high_sync_ff <= 3'h0;
      rc_sync_ff <= 2'h0;
    end else begin
      low_sync_ff <= {low_sync_ff[1:0], low_osc_pin_in};
      high_sync_ff <= {high_sync_ff[1:0], high_osc_pin_in};
      rc_sync_ff <= {rc_sync_ff[0], rc_low_osc_in};
    end
  end

  assign low_edge = low_sync_ff[1] & ~low_sync_ff[2];
  assign high_edge = high_sync_ff[1] & ~high_sync_ff[2];
  assign clock_timer_tick_out = low_edge; // RULE3

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0] timer_ctrl_ff;
  logic [3:0] nxt_timer_ctrl;
  logic cpu_sel_ff;
  logic nxt_cpu_sel;
  logic high_en_ff;
  logic nxt_high_en;
  logic [1:0] mode_ff;
  logic [1:0] nxt_mode;
  logic wd_strobe_ff;
  logic nxt_wd_strobe;
  logic tm_strobe_ff;
  logic nxt_tm_strobe;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] status;
  logic sleep_ff;
  logic low_stop_ff;
  logic high_run_ff;
  logic high_running;
  logic div_en_ff;
  logic nxt_div_en;
  clock_control_pkg::mux_state_e state_ff;
  clock_control_pkg::mux_state_e nxt_state;

  assign status = {3'h0, sleep_ff, low_stop_ff, high_running, cpu_on_high_out, rc_sync_ff[1]};

  always_comb begin
    nxt_timer_ctrl = timer_ctrl_ff;
    nxt_cpu_sel = cpu_sel_ff;
    nxt_high_en = high_en_ff;
    nxt_mode = mode_ff;
    nxt_wd_strobe = 1'b0;
    nxt_tm_strobe = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_div_en = div_en_ff;
    if (wr_in && addr_in == clock_control_pkg::TIMER_CTRL_ADDR) begin
      nxt_timer_ctrl = {wdata_in[clock_control_pkg::DIV_SEL_MSB:clock_control_pkg::DIV_SEL_LSB],
                        wdata_in[clock_control_pkg::TIMER_RUN_BIT]};
      nxt_wd_strobe = wdata_in[clock_control_pkg::WD_RESTART_BIT];
      nxt_tm_strobe = wdata_in[clock_control_pkg::TIMER_RESTART_BIT];
      nxt_div_en = wdata_in[clock_control_pkg::DIV_EN_BIT];
    end
    if (wr_in && addr_in == clock_control_pkg::OSC_CTRL_ADDR) begin
      nxt_cpu_sel = wdata_in[clock_control_pkg::CPU_SEL_BIT]; // RULE18
      nxt_high_en = wdata_in[clock_control_pkg::HIGH_EN_BIT]; // RULE19
      nxt_mode = wdata_in[clock_control_pkg::MODE_MSB:clock_control_pkg::MODE_LSB]; // RULE17
    end
    if (rd_in) begin
      case (addr_in)
        clock_control_pkg::TIMER_CTRL_ADDR: nxt_rdata = {1'b0, timer_ctrl_ff[3:1], div_en_ff,
                                                          2'h0, timer_ctrl_ff[0]};
        clock_control_pkg::OSC_CTRL_ADDR: nxt_rdata = {4'h0, cpu_sel_ff, high_en_ff, mode_ff}; // RULE19
        clock_control_pkg::STATUS_ADDR: nxt_rdata = status;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      timer_ctrl_ff <= clock_control_pkg::REG_RESET[3:0];
      cpu_sel_ff <= 1'b0; // RULE2
      high_en_ff <= 1'b0; // RULE2
      mode_ff <= clock_control_pkg::MODE_NORMAL; // RULE6
      wd_strobe_ff <= 1'b0;
      tm_strobe_ff <= 1'b0;
      rdata_ff <= clock_control_pkg::REG_RESET;
      div_en_ff <= 1'b0;
    end else begin
      timer_ctrl_ff <= nxt_timer_ctrl;
      cpu_sel_ff <= nxt_cpu_sel;
      high_en_ff <= nxt_high_en;
      mode_ff <= nxt_mode;
      wd_strobe_ff <= nxt_wd_strobe;
      tm_strobe_ff <= nxt_tm_strobe;
      rdata_ff <= nxt_rdata;
      div_en_ff <= nxt_div_en;
    end
  end

  assign rdata_out = rdata_ff;
  assign watchdog_restart_strobe_out = wd_strobe_ff;
  assign clock_timer_restart_strobe_out = tm_strobe_ff;
  assign clock_timer_run_out = timer_ctrl_ff[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep, standby, oscillator enables and fast oscillator settling
  localparam int TICK_W = $clog2(STABLE_TICKS + 1);
  logic [TICK_W-1:0] stable_cnt_ff;
  logic [TICK_W-1:0] nxt_stable_cnt;
  logic nxt_sleep;
  logic nxt_low_stop;
  logic nxt_high_run;

  always_comb begin
    nxt_sleep = sleep_ff;
    nxt_low_stop = low_stop_ff;
    nxt_stable_cnt = stable_cnt_ff;
    if (sleep_instruction_in) begin
      nxt_sleep = 1'b1;
    end
    // A detector sample in progress keeps the slow clock alive until it ends
    if (sleep_ff && !supply_voltage_detector_sampling_in) begin
      nxt_low_stop = 1'b1; // RULE4
    end
    // Registers are left alone, so wake resumes the old clock and mode
    if (wake_in) begin
      nxt_sleep = 1'b0; // RULE15
      nxt_low_stop = 1'b0; // RULE15
    end
    nxt_high_run = nxt_high_en & ~nxt_sleep; // RULE5
    // Fixed edge count stands in for the oscillator start-up time
    if (!high_run_ff) begin
      nxt_stable_cnt = '0;
    end else if (high_edge && !high_running) begin
      nxt_stable_cnt = stable_cnt_ff + TICK_W'(1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      sleep_ff <= 1'b0;
      low_stop_ff <= 1'b0; // RULE1
      high_run_ff <= 1'b0; // RULE2
      stable_cnt_ff <= '0;
    end else begin
      sleep_ff <= nxt_sleep;
      low_stop_ff <= nxt_low_stop;
      high_run_ff <= nxt_high_run;
      stable_cnt_ff <= nxt_stable_cnt;
    end
  end

  assign high_running = (stable_cnt_ff == TICK_W'(STABLE_TICKS)); // RULE20

  ////////////////////////////////////////////////////////////////////////////////
  // Operating mode and CPU clock multiplexer
  logic [1:0] op_mode_ff;
  logic [1:0] nxt_op_mode;
  logic cpu_tick_ff;
  logic nxt_tick;
  logic want_high;

  always_comb begin
    // RC slow oscillator needs the normal mode supply to hold its rate
    nxt_op_mode = rc_sync_ff[1] ? clock_control_pkg::MODE_NORMAL : nxt_mode; // RULE10
    // Select without a running fast oscillator is ignored
    want_high = cpu_sel_ff & high_run_ff & high_running; // RULE21
    nxt_state = state_ff;
    nxt_tick = 1'b0;
    case (state_ff)
      clock_control_pkg::ON_LOW: begin
        nxt_tick = low_edge;
        if (want_high) begin
          nxt_state = clock_control_pkg::TO_HIGH; // RULE11
        end
      end
      // No ticks until the new source shows a whole edge
      clock_control_pkg::TO_HIGH: begin
        if (!want_high) begin
          nxt_state = clock_control_pkg::ON_LOW;
        end else if (high_edge) begin
          nxt_state = clock_control_pkg::ON_HIGH; // RULE20
          nxt_tick = 1'b1;
        end
      end
      clock_control_pkg::ON_HIGH: begin
        nxt_tick = high_edge;
        if (!want_high) begin
          nxt_state = clock_control_pkg::TO_LOW; // RULE11
        end
      end
      clock_control_pkg::TO_LOW: begin
        if (low_edge) begin
          nxt_state = clock_control_pkg::ON_LOW; // RULE20
          nxt_tick = 1'b1;
        end
      end
      default: begin
        nxt_state = clock_control_pkg::ON_LOW;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state_ff <= clock_control_pkg::ON_LOW; // RULE2
      cpu_tick_ff <= 1'b0;
      op_mode_ff <= clock_control_pkg::MODE_NORMAL; // RULE6
    end else begin
      state_ff <= nxt_state;
      cpu_tick_ff <= nxt_tick;
      op_mode_ff <= nxt_op_mode;
    end
  end

  assign cpu_tick_out = cpu_tick_ff;
  assign cpu_on_high_out = (state_ff == clock_control_pkg::ON_HIGH); // RULE11
  assign op_mode_out = op_mode_ff; // RULE17
  assign high_speed_mode_out = op_mode_ff[1]; // RULE7
  assign low_speed_oscillator_enable_out = ~low_stop_ff; // RULE1
  assign high_speed_oscillator_enable_out = high_run_ff; // RULE5

  ////////////////////////////////////////////////////////////////////////////////
  // Divided clock output
  divided_clock_if dcif ();

  assign dcif.low_level = low_sync_ff[1];
  assign dcif.high_level = high_sync_ff[1];
  assign dcif.low_edge = low_edge;
  assign dcif.high_edge = high_edge;
  assign dcif.div_sel = timer_ctrl_ff[3:1];
  assign dcif.div_en = div_en_ff;
  assign divided_clock_output_out = dcif.div_out;

  divided_clock_output i_divided_clock_output (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .dc(dcif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence high_edge_in_handover;
    (state_ff == clock_control_pkg::TO_HIGH && want_high) ##0 high_edge;
  endsequence
  sequence low_edge_in_handover;
    (state_ff == clock_control_pkg::TO_LOW) ##0 low_edge;
  endsequence
  chk_high_handover: assert property ( // RULE20
    high_edge_in_handover |=> state_ff == clock_control_pkg::ON_HIGH)
    else $error("fast clock handover missed its edge");
  chk_low_handover: assert property ( // RULE20
    low_edge_in_handover |=> state_ff == clock_control_pkg::ON_LOW && cpu_tick_out)
    else $error("slow clock handover missed its edge");
  chk_no_runt_tick: assert property ( // RULE20
    (state_ff == clock_control_pkg::TO_LOW && !low_edge) |=> !cpu_tick_out)
    else $error("cpu tick during clock handover");
  chk_leave_high_off: assert property ( // RULE21
    (state_ff == clock_control_pkg::ON_HIGH && !high_run_ff) |=> state_ff == clock_control_pkg::TO_LOW)
    else $error("cpu stayed on a stopped fast clock");
  chk_sleep_stops_high: assert property ( // RULE5
    (sleep_instruction_in && !wake_in) |=> !high_speed_oscillator_enable_out)
    else $error("fast oscillator kept running in sleep");
  chk_low_waits_svd: assert property ( // RULE4
    (!low_stop_ff && supply_voltage_detector_sampling_in) |=> !low_stop_ff)
    else $error("slow oscillator stopped during detector sample");
  chk_rc_forces_normal: assert property ( // RULE10
    rc_sync_ff[1] |=> op_mode_out == clock_control_pkg::MODE_NORMAL)
    else $error("mode not normal with rc slow oscillator");
endmodule : clock_control

// file: testbench/clock_control_tb_top.sv
// Self-checking bench for the oscillator clock control block
`timescale 1ns/1ps
module clock_control_tb_top;
  `define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
  `define WAITFOR(c, n) begin k = 0; while (!(c) && k < (n)) begin @(posedge clock_in); k++; end end
  logic clock_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [23:0] addr_in = 24'h000000;
  logic [7:0] wdata_in = 8'h00, rdata_out;
  logic low_osc_pin_in = 1'b0, high_osc_pin_in = 1'b0, rc_low_osc_in = 1'b0;
  logic sleep_instruction_in = 1'b0, supply_voltage_detector_sampling_in = 1'b0, wake_in = 1'b0;
  logic low_en, high_en, cpu_tick, on_high, hs_mode, tm_tick, div_out, wd_stb, tm_stb, tm_run;
  logic [1:0] op_mode;
  int n_errors = 0, n_compared = 0, cyc = 0, k, n_div = 0, n_tm = 0, n_cpu = 0;
  typedef struct {logic [23:0] a; logic [7:0] d; logic [7:0] rb;} row_s;
  row_s rows[8];
  clock_control i_clock_control (.clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .low_osc_pin_in(low_osc_pin_in), .high_osc_pin_in(high_osc_pin_in), .rc_low_osc_in(rc_low_osc_in),
    .sleep_instruction_in(sleep_instruction_in),
    .supply_voltage_detector_sampling_in(supply_voltage_detector_sampling_in), .wake_in(wake_in),
    .low_speed_oscillator_enable_out(low_en), .high_speed_oscillator_enable_out(high_en),
    .cpu_tick_out(cpu_tick), .cpu_on_high_out(on_high), .op_mode_out(op_mode),
    .high_speed_mode_out(hs_mode), .clock_timer_tick_out(tm_tick), .divided_clock_output_out(div_out),
    .watchdog_restart_strobe_out(wd_stb), .clock_timer_restart_strobe_out(tm_stb),
    .clock_timer_run_out(tm_run));
  initial begin
    forever #50 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator pins only toggle while their enables are up
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    low_osc_pin_in <= cyc[3] & low_en;
    high_osc_pin_in <= cyc[0] & high_en;
    if (resetn_in) begin
      n_div <= n_div + div_out;
      n_tm <= n_tm + tm_tick;
      n_cpu <= n_cpu + cpu_tick;
    end
    if (cyc > 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr
  // Read data arrive in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [23:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    d = rdata_out;
  endtask : rd
  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] r;
    int d0;
    rows = '{'{clock_control_pkg::OSC_CTRL_ADDR, 8'h01, 8'h01}, '{clock_control_pkg::OSC_CTRL_ADDR, 8'h00, 8'h00},
      '{clock_control_pkg::OSC_CTRL_ADDR, 8'h02, 8'h02}, '{clock_control_pkg::OSC_CTRL_ADDR, 8'h03, 8'h03},
      '{clock_control_pkg::OSC_CTRL_ADDR, 8'h00, 8'h00}, '{clock_control_pkg::OSC_CTRL_ADDR, 8'h04, 8'h04},
      '{clock_control_pkg::TIMER_CTRL_ADDR, 8'hff, 8'h79}, '{clock_control_pkg::TIMER_CTRL_ADDR, 8'h00, 8'h00}};
    repeat (16) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rd(clock_control_pkg::OSC_CTRL_ADDR, r);
    `CHK("osc_ctrl_reset", 4'h0, r[3:0])
    rd(clock_control_pkg::TIMER_CTRL_ADDR, r);
    `CHK("timer_ctrl_reset", clock_control_pkg::REG_RESET, r)
    `CHK("reset_cpu_high", 1'b0, on_high)
    `CHK("reset_high_en", 1'b0, high_en)
    `CHK("reset_low_en", 1'b1, low_en)
    `CHK("reset_mode", clock_control_pkg::MODE_NORMAL, op_mode)
    foreach (rows[i]) begin
      repeat (5) @(posedge clock_in);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, r);
      if (rows[i].a == clock_control_pkg::OSC_CTRL_ADDR) begin
        `CHK("osc_readback", rows[i].rb[3:0], r[3:0])
        `CHK("op_mode", rows[i].d[1:0], op_mode)
        `CHK("hs_mode", rows[i].d[1], hs_mode)
        `CHK("high_en", rows[i].d[2], high_en)
      end else begin
        `CHK("timer_readback", rows[i].rb, r)
        `CHK("timer_run", rows[i].d[0], tm_run)
      end
    end
    // Selecting the fast clock while its oscillator is off is ignored
    wr(clock_control_pkg::OSC_CTRL_ADDR, 8'h08);
    repeat (40) @(posedge clock_in);
    `CHK("select_while_off", 1'b0, on_high)
    wr(clock_control_pkg::OSC_CTRL_ADDR, 8'h04);
    repeat (20) @(posedge clock_in);
    wr(clock_control_pkg::OSC_CTRL_ADDR, 8'h0c);
    `WAITFOR(on_high === 1'b1, 300)
    `CHK("switch_to_high", 1'b1, on_high)
    `CHK("low_runs_on_high", 1'b1, low_en)
    wr(clock_control_pkg::OSC_CTRL_ADDR, 8'h04);
    `WAITFOR(on_high === 1'b0, 300)
    `CHK("switch_to_low", 1'b0, on_high)
    wr(clock_control_pkg::OSC_CTRL_ADDR, 8'h00);
    repeat (3) @(posedge clock_in);
    `CHK("high_off", 1'b0, high_en)
    // RC low oscillator pins the mode to normal
    rc_low_osc_in <= 1'b1;
    wr(clock_control_pkg::OSC_CTRL_ADDR, 8'h02);
    repeat (3) @(posedge clock_in);
    `CHK("rc_mode", clock_control_pkg::MODE_NORMAL, op_mode)
    `CHK("rc_hs_mode", 1'b0, hs_mode)
    wr(clock_control_pkg::OSC_CTRL_ADDR, 8'h04);
    rc_low_osc_in <= 1'b0;
    // Sleep while the detector samples: low stop waits for it
    repeat (20) @(posedge clock_in);
    supply_voltage_detector_sampling_in <= 1'b1;
    sleep_instruction_in <= 1'b1;
    @(posedge clock_in);
    sleep_instruction_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    `CHK("sleep_deferred", 1'b1, low_en)
    `CHK("sleep_high_off", 1'b0, high_en)
    supply_voltage_detector_sampling_in <= 1'b0;
    `WAITFOR(low_en === 1'b0, 20)
    `CHK("sleep_low_off", 1'b0, low_en)
    wake_in <= 1'b1;
    @(posedge clock_in);
    wake_in <= 1'b0;
    `WAITFOR(low_en === 1'b1 && high_en === 1'b1, 50)
    `CHK("wake_low", 1'b1, low_en)
    `CHK("wake_high", 1'b1, high_en)
    rd(clock_control_pkg::OSC_CTRL_ADDR, r);
    `CHK("wake_readback", 4'h4, r[3:0])
    // Restart strobes are single pulses after the write
    wr(clock_control_pkg::TIMER_CTRL_ADDR, 8'h06);
    @(negedge clock_in);
    `CHK("wd_strobe", 1'b1, wd_stb)
    `CHK("tm_strobe", 1'b1, tm_stb)
    @(negedge clock_in);
    `CHK("wd_strobe_end", 1'b0, wd_stb)
    `CHK("tm_strobe_end", 1'b0, tm_stb)
    `CHK("div_off", 1'b0, div_out)
    // Divide by one from the slow oscillator
    d0 = n_div;
    wr(clock_control_pkg::TIMER_CTRL_ADDR, 8'h08);
    repeat (40) @(posedge clock_in);
    `CHK("div_active", 1'b1, n_div > d0)
    `CHK("tm_ticks", 1'b1, n_tm > 0)
    `CHK("cpu_ticks", 1'b1, n_cpu > 0)
    test_done();
  end
endmodule : clock_control_tb_top
